// ### hdl/slid_core.sv
// serial status lock write and id readout logic of the flash device
`timescale 1ns/1ps
module slid_core #(
	parameter logic [7:0] STATUS_WRITE_CMD = 8'h01,
	parameter logic [7:0] STATUS_WRITE_ARM_CMD = 8'h50,
	parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3c // arbitrary value
) (
	// clocking
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// serial host pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	// serial data out
	output logic so,
	output logic so_oe,
	// status protection fields
	output logic block_protect_hi,
	output logic block_protect_lo,
	output logic protect_lock_bit,
	// arming state
	output logic status_write_armed
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the raw pins are xored with the idle levels so the
	// filtered copy comes out of reset deselected, clock low, protect high
	localparam slid_pkg::slid_pins_s IDLE_PINS = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1};

	slid_pkg::slid_pins_s pins_raw;
	slid_pkg::slid_pins_s pins_xor;
	slid_pkg::slid_pins_s pin_f;
	slid_pkg::slid_pins_s pin_d;

	assign pins_raw = '{sck: sck, cs_n: cs_n, si: si, wp_n: wp_n};
	assign pins_xor = pins_raw ^ IDLE_PINS;

	slid_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.pin_in(pins_xor),
		.rst_val(IDLE_PINS),
		.pin_out(pin_f)
	);

	// previous filtered levels for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_d <= IDLE_PINS;
		end else if (ce) begin
			pin_d <= pin_f;
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	// edges of the filtered pins; select edges take priority over clock edges
	// clock edges seen while deselected belong to another device on the bus,
	// so they are masked here rather than in every state of the sequencer
	assign sck_rise = pin_f.sck & ~pin_d.sck & ~pin_f.cs_n;
	assign sck_fall = ~pin_f.sck & pin_d.sck & ~pin_f.cs_n;
	assign cs_fall = ~pin_f.cs_n & pin_d.cs_n;
	assign cs_rise = pin_f.cs_n & ~pin_d.cs_n;

	////////////////////////////////////////////////////////////////////////////
	// instruction sequencer
	slid_pkg::slid_state_e state;
	slid_pkg::slid_state_e next_state;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic [7:0] in_sh;
	logic [7:0] next_in_sh;
	logic [7:0] opcode;
	logic [7:0] next_opcode;
	logic [7:0] data_byte;
	logic [7:0] next_data_byte;
	logic cmd_done;
	logic next_cmd_done;
	logic data_done;
	logic next_data_done;
	logic start_sel;
	logic next_start_sel;
	logic [7:0] shifted;

	// bits enter at the bottom, so the first bit ends up on top
	assign shifted = {in_sh[6:0], pin_f.si};

	// next sequencer values; every field defaults to holding, so a frame
	// cut short at any bit leaves nothing half-updated
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_in_sh = in_sh;
		next_opcode = opcode;
		next_data_byte = data_byte;
		next_cmd_done = cmd_done;
		next_data_done = data_done;
		next_start_sel = start_sel;
		if (cs_rise) begin
			// select rise ends any instruction, even one stopped mid byte
			next_state = slid_pkg::ST_IDLE;
		end else if (cs_fall) begin
			// a fresh instruction always starts with an opcode
			next_state = slid_pkg::ST_CMD;
			next_bit_cnt = '0;
			next_cmd_done = 1'b0;
			next_data_done = 1'b0;
		end else if (sck_rise) begin
			// input bits are taken only at a rising serial clock
			next_in_sh = shifted;
			next_bit_cnt = bit_cnt + 5'h01;
			case (state)
				slid_pkg::ST_CMD: begin
					if (bit_cnt == slid_pkg::CMD_LAST) begin
						next_opcode = shifted;
						next_cmd_done = 1'b1;
						next_bit_cnt = '0;
						if (shifted == slid_pkg::OP_ID_A || shifted == slid_pkg::OP_ID_B) begin
							next_state = slid_pkg::ST_ADDR;
						end else if (shifted == STATUS_WRITE_CMD) begin
							next_state = slid_pkg::ST_DATA;
						end else begin
							next_state = slid_pkg::ST_SKIP;
						end
					end
				end
				slid_pkg::ST_ADDR: begin
					if (bit_cnt == slid_pkg::ADDR_LAST) begin
						// only the lowest address bit selects a code
						next_start_sel = pin_f.si;
						next_bit_cnt = '0;
						next_state = slid_pkg::ST_IDOUT;
					end
				end
				slid_pkg::ST_DATA: begin
					if (bit_cnt == slid_pkg::DATA_LAST) begin
						next_data_byte = shifted;
						next_data_done = 1'b1;
						next_state = slid_pkg::ST_SKIP;
					end
				end
				slid_pkg::ST_IDOUT: begin
					// the id shifter keeps its own count; input bits are ignored
					next_bit_cnt = bit_cnt;
				end
				slid_pkg::ST_SKIP: begin
					// unknown opcodes and bits past the data byte are dropped here
					next_bit_cnt = bit_cnt;
				end
				default: begin
					// unused codes fall back to idle until the next select fall
					next_state = slid_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// sequencer registers; ce low holds them all
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= slid_pkg::ST_IDLE;
			bit_cnt <= '0;
			in_sh <= '0;
			opcode <= '0;
			data_byte <= '0;
			cmd_done <= 1'b0;
			data_done <= 1'b0;
			start_sel <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			in_sh <= next_in_sh;
			opcode <= next_opcode;
			data_byte <= next_data_byte;
			cmd_done <= next_cmd_done;
			data_done <= next_data_done;
			start_sel <= next_start_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arming and protection fields, all decided at select rising
	slid_pkg::slid_prot_s prot;
	slid_pkg::slid_prot_s next_prot;
	logic next_armed;
	logic is_arm;
	logic is_write;
	logic permit;

	assign is_arm = cmd_done && opcode == STATUS_WRITE_ARM_CMD;
	assign is_write = cmd_done && data_done && opcode == STATUS_WRITE_CMD;
	// pin level and lock as they stand just before select rose
	// the pin filter delays wp_n and cs_n alike, so their order is kept
	assign permit = pin_f.wp_n | ~prot.protect_lock_bit;

	// arming lives only from one select rise to the next, so any frame in
	// between, even an empty one, wastes it
	always_comb begin
		next_armed = status_write_armed;
		next_prot = prot;
		if (cs_rise) begin
			// any other finished or aborted cycle wastes the arming
			next_armed = is_arm;
			if (is_write && status_write_armed && permit) begin
				// lock was clear or pin high, so with the pin low the lock may only rise, never fall
				next_prot.protect_lock_bit = data_byte[slid_pkg::DATA_LOCK_POS];
				next_prot.block_protect_hi = data_byte[slid_pkg::DATA_BP_HI_POS];
				next_prot.block_protect_lo = data_byte[slid_pkg::DATA_BP_LO_POS];
			end
		end
	end

	// fields reset to clear; no nonvolatile copy is kept here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_write_armed <= 1'b0;
			prot <= '{protect_lock_bit: slid_pkg::PROT_LOCK_RST, block_protect_hi: slid_pkg::PROT_HI_RST,
				block_protect_lo: slid_pkg::PROT_LO_RST};
		end else if (ce) begin
			status_write_armed <= next_armed;
			prot <= next_prot;
		end
	end

	// status fields leave straight from the prot flops
	assign protect_lock_bit = prot.protect_lock_bit;
	assign block_protect_hi = prot.block_protect_hi;
	assign block_protect_lo = prot.block_protect_lo;

	////////////////////////////////////////////////////////////////////////////
	// id byte shifter, updated on falling serial clock
	logic [7:0] out_sh;
	logic [7:0] next_out_sh;
	logic [2:0] out_cnt;
	logic [2:0] next_out_cnt;
	logic sel;
	logic next_sel;
	logic next_so;
	logic next_so_oe;
	logic [7:0] id_byte;

	// sel low reads address 00000h, high reads 00001h
	assign id_byte = sel ? DEV_CODE : MFR_CODE;

	// first bit leaves at the first falling clock after the last address bit,
	// so the host sees it settled before its next rising edge
	always_comb begin
		next_out_sh = out_sh;
		next_out_cnt = out_cnt;
		next_sel = sel;
		next_so = so;
		next_so_oe = so_oe;
		if (cs_rise || cs_fall) begin
			// output released as soon as select rises
			next_so_oe = 1'b0;
			next_so = 1'b0;
			next_out_cnt = '0;
		end else if (state != slid_pkg::ST_IDOUT) begin
			// start code follows the captured address bit
			next_sel = next_start_sel;
			next_out_cnt = '0;
		end else if (sck_fall) begin
			next_so_oe = 1'b1;
			next_out_cnt = out_cnt + 3'h1;
			if (out_cnt == 3'h0) begin
				next_so = id_byte[7];
				next_out_sh = {id_byte[6:0], 1'b0};
			end else begin
				next_so = out_sh[7];
				next_out_sh = {out_sh[6:0], 1'b0};
			end
			if (out_cnt == slid_pkg::OUT_LAST) begin
				next_sel = ~sel;
			end
		end
	end

	// output registers; so and so_oe leave straight from these flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_sh <= '0;
			out_cnt <= '0;
			sel <= 1'b0;
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (ce) begin
			out_sh <= next_out_sh;
			out_cnt <= next_out_cnt;
			sel <= next_sel;
			so <= next_so;
			so_oe <= next_so_oe;
		end
	end

endmodule

// ### hdl/slid_pkg.sv
// constants, carriers and opcodes for the status lock and id read block
// Function
// - accepted status write changes only both block protect bits and the lock bit
// - status write ignored entirely while write protect pin low and lock bit set
// - with write protect pin low, lock bit may go 0 to 1 only
// - with write protect pin high, lock and block protect bits freely writable
// - permission judged from lock bit and pin level before select rises
// - one permitted status write sets lock and both protect bits together
// - select low before command, status write executes only on select rising
// - id read opcode 90h or abh, then 24 address bits, both handled alike
// - id address 00000h gives manufacturer code, 00001h gives device code
// - id bytes alternate while select stays low, stop when select rises
// - arming instruction not followed at once by status write has no effect
// - arming instruction acts only after select low then high
package slid_pkg;

	////////////////////////////////////////////////////////////////////////////
	// opcodes of the id read
	localparam logic [7:0] OP_ID_A = 8'h90;
	localparam logic [7:0] OP_ID_B = 8'hab;

	// shift counts of each instruction phase
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] ADDR_LAST = 5'h17;
	localparam logic [4:0] DATA_LAST = 5'h07;
	localparam logic [2:0] OUT_LAST = 3'h7;

	// positions of the writable fields in the status data byte
	localparam int DATA_LOCK_POS = 7;
	localparam int DATA_BP_HI_POS = 3;
	localparam int DATA_BP_LO_POS = 2;

	// status values after reset
	localparam logic PROT_LOCK_RST = 1'b0;
	localparam logic PROT_HI_RST = 1'b0;
	localparam logic PROT_LO_RST = 1'b0;

	// synchroniser stages on each pin input
	localparam int SYNC_STAGES = 3;

	////////////////////////////////////////////////////////////////////////////
	// pin group from the serial host
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic si;
		logic wp_n;
	} slid_pins_s;

	// protection fields of the status register
	typedef struct packed {
		logic protect_lock_bit;
		logic block_protect_hi;
		logic block_protect_lo;
	} slid_prot_s;

	// instruction sequencer states, gray along idle-cmd-addr-out
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b011,
		ST_IDOUT = 3'b010,
		ST_DATA = 3'b101,
		ST_SKIP = 3'b100
	} slid_state_e;

endpackage

// ### hdl/slid_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module slid_sync #(
	parameter int WIDTH = 4
) (
	// clocking
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// pins in, filtered levels out
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] rst_val,
	output logic [WIDTH-1:0] pin_out
);

	////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			logic lvl;
			logic next_lvl;

			// a change counts only once stages two and three agree
			always_comb begin
				next_lvl = lvl;
				if (s2 == s3) begin
					next_lvl = s3;
				end
			end

			// first stage feeds only the second; reset to idle levels
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					lvl <= 1'b0;
				end else if (ce) begin
					s1 <= pin_in[g];
					s2 <= s1;
					s3 <= s2;
					lvl <= next_lvl;
				end
			end

			assign pin_out[g] = lvl ^ rst_val[g];
		end
	endgenerate

endmodule

// ### test/slid_host.sv
// serial host model driving select, clock and data pins
`timescale 1ns/1ps
module slid_host (
	// clocking
	input wire logic clk,
	// host pins
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	////////////////////////////////////////
	// every phase held at least 8 clk, above the 5 the pin filter needs
	task automatic ph(input int n);
		repeat (n) @(posedge clk);
	endtask
	// select low opens a frame, sck idles low and still
	task automatic sel();
		ph(8);
		cs_n <= 1'b0;
		ph(8);
	endtask
	// released data line stops showing the last bit
	task automatic desel();
		ph(8);
		cs_n <= 1'b1;
		si <= ~si;
		ph(10);
	endtask
	// one byte out and in, msb first; so sampled before each rise
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si <= d[i];
			ph(8);
			r[i] = so;
			sck <= 1'b1;
			ph(8);
			sck <= 1'b0;
		end
	endtask
endmodule

// ### test/slid_chk.sv
// port assertions for the status lock and id read block
`timescale 1ns/1ps
module slid_chk (
	// clocking
	input wire logic clk,
	input wire logic reset_n,
	// pins
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic so_oe,
	// status
	input wire logic block_protect_hi,
	input wire logic block_protect_lo,
	input wire logic protect_lock_bit,
	input wire logic status_write_armed
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	logic [2:0] f;
	assign f = {protect_lock_bit, block_protect_hi, block_protect_lo};
	////////////////////////////////////////
	// pin lag of about 5 clk covered by 8 cycle windows
	property p_fld_cs;
		(!cs_n) [*8] |-> $stable(f);
	endproperty
	a_fld_cs: assert property (p_fld_cs) else $error("status moved while selected");
	property p_lock;
		(protect_lock_bit && !wp_n) [*8] |=> $stable(f);
	endproperty
	a_lock: assert property (p_lock) else $error("locked status changed");
	property p_lock_wp;
		(!wp_n) [*8] ##0 protect_lock_bit |=> protect_lock_bit;
	endproperty
	a_lock_wp: assert property (p_lock_wp) else $error("lock cleared with pin low");
	property p_arm_only;
		$changed(f) |-> $past(status_write_armed);
	endproperty
	a_arm_only: assert property (p_arm_only) else $error("status changed unarmed");
	property p_arm_drop;
		status_write_armed && $rose(cs_n) |-> ##[1:8] !status_write_armed;
	endproperty
	a_arm_drop: assert property (p_arm_drop) else $error("arming outlived next frame");
	property p_arm_set;
		$rose(status_write_armed) |-> cs_n;
	endproperty
	a_arm_set: assert property (p_arm_set) else $error("armed while selected");
	property p_oe_off;
		cs_n [*8] |-> !so_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	property p_oe_on;
		$rose(so_oe) |-> !cs_n;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output enabled without select");
	c_lock: cover property ($rose(protect_lock_bit));
	c_oe: cover property ($rose(so_oe));
	c_arm: cover property ($rose(status_write_armed));
endmodule
bind slid_core slid_chk i_chk (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .wp_n(wp_n), .so_oe(so_oe),
	.block_protect_hi(block_protect_hi), .block_protect_lo(block_protect_lo),
	.protect_lock_bit(protect_lock_bit), .status_write_armed(status_write_armed));

// ### test/tb.sv
// self-checking bench for the status lock and id read block
`timescale 1ns/1ps
module tb;
	typedef struct {
		logic wp;
		logic [7:0] d;
		logic [2:0] exp;
	} slid_row_s;
	localparam logic [7:0] MFR = 8'h5a; // arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // arbitrary value
	logic clk, reset_n, ce, wp_n, sck, cs_n, si, so, so_oe, hi, lo, lk, armed;
	logic [7:0] r;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	// status writes from reset, lock and pin in every mix
	slid_row_s rows [7] = '{'{1'b1, 8'h0c, 3'h3}, '{1'b1, 8'h84, 3'h5}, '{1'b0, 8'h00, 3'h5},
		'{1'b1, 8'h08, 3'h2}, '{1'b0, 8'h8c, 3'h7}, '{1'b0, 8'h00, 3'h7}, '{1'b1, 8'h73, 3'h0}};
	slid_core #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_slid_core (.clk(clk), .reset_n(reset_n), .ce(ce),
		.sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .block_protect_hi(hi),
		.block_protect_lo(lo), .protect_lock_bit(lk), .status_write_armed(armed));
	slid_host i_slid_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// run is about 10k cycles, so 20k means a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// one select frame of n leading bytes of b
	task automatic frame(input logic [31:0] b, input int n);
		i_slid_host.sel();
		for (int k = 0; k < n; k++) begin
			i_slid_host.xfer(b[31-8*k -: 8], r);
		end
		i_slid_host.desel();
	endtask
	task automatic status_write_cmd(input logic [7:0] d);
		frame({8'h50, 24'h0}, 1);
		chk("armed", {7'h0, armed}, 8'h01);
		frame({8'h01, d, 16'h0}, 2);
		chk("disarmed", {7'h0, armed}, 8'h00);
	endtask
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		wp_n = 1'b1;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		chk("reset", {4'h0, so_oe, lk, hi, lo}, 8'h00);
		$display("reset test done");
		foreach (rows[j]) begin
			wp_n <= rows[j].wp;
			status_write_cmd(rows[j].d);
			chk("fields", {5'h0, lk, hi, lo}, {5'h0, rows[j].exp});
			$display("row %0d done", j);
		end
		// unarmed write, then arming wasted by an empty frame
		frame({8'h01, 8'h8c, 16'h0}, 2);
		frame({8'h50, 24'h0}, 1);
		frame(32'h0, 0);
		frame({8'h01, 8'h8c, 16'h0}, 2);
		chk("unarmed", {5'h0, lk, hi, lo}, 8'h00);
		// arming wasted by an unknown four byte instruction in between
		frame({8'h50, 24'h0}, 1);
		frame({8'h0f, 24'h000001}, 4);
		frame({8'h01, 8'h8c, 16'h0}, 2);
		chk("other_op", {4'h0, armed, lk, hi, lo}, 8'h00);
		$display("unarmed test done");
		// locked with pin low, pin raised just before select rises
		status_write_cmd(8'h80);
		wp_n <= 1'b0;
		frame({8'h50, 24'h0}, 1);
		i_slid_host.sel();
		i_slid_host.xfer(8'h01, r);
		i_slid_host.xfer(8'h0c, r);
		wp_n <= 1'b1;
		i_slid_host.desel();
		chk("late_pin", {5'h0, lk, hi, lo}, 8'h03);
		$display("late pin test done");
		// reset in mid-run drops fields and arming
		frame({8'h50, 24'h0}, 1);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("mid_reset", {3'h0, armed, so_oe, lk, hi, lo}, 8'h00);
		reset_n <= 1'b1;
		// clock enable low: a full arm and write pass unseen
		ce <= 1'b0;
		frame({8'h50, 24'h0}, 1);
		frame({8'h01, 8'h8c, 16'h0}, 2);
		ce <= 1'b1;
		chk("ce_hold", {4'h0, armed, lk, hi, lo}, 8'h00);
		$display("reset and enable test done");
		// both opcodes, both address parities, three bytes each
		for (int m = 0; m < 4; m++) begin
			i_slid_host.sel();
			i_slid_host.xfer(m[1] ? 8'hab : 8'h90, r);
			i_slid_host.xfer(8'h00, r);
			i_slid_host.xfer(8'h00, r);
			i_slid_host.xfer({7'h0, m[0]}, r);
			for (int k = 0; k < 3; k++) begin
				i_slid_host.xfer(8'hff, r);
				chk("id", r, (m[0] ^ k[0]) ? DEV : MFR);
			end
			i_slid_host.desel();
			chk("oe_off", {7'h0, so_oe}, 8'h00);
		end
		$display("id test done");
		test_done();
	end
endmodule
